// ---- hdl/msc_map.vh ----
// Constants for the motor speed command loop
`ifndef MSC_MAP_VH
`define MSC_MAP_VH

// ----------------------------------------------------------------
// Speed source and feedback source encodings
// ----------------------------------------------------------------
`define MSC_MODE_FREQ 2'h0
`define MSC_MODE_CLK_DUTY 2'h1
`define MSC_MODE_REG_DUTY 2'h2
`define MSC_FB_AMP 2'h0
`define MSC_FB_ROTATION 2'h1
`define MSC_FB_HALL 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MSC_CLK_HZ 100000000
`define MSC_BASE_HZ 50000000
`define MSC_BASE_DIV (`MSC_CLK_HZ / `MSC_BASE_HZ)
`define MSC_SAMPLE_HZ 195000
`define MSC_SAMPLE_DIV (`MSC_CLK_HZ / `MSC_SAMPLE_HZ)

// ----------------------------------------------------------------
// Duty and gain scaling
// ----------------------------------------------------------------
`define MSC_DUTY_MAX 12'hFFF
`define MSC_DUTY_BITS 12
`define MSC_MOD_SHIFT 11
`define MSC_FILT_X_SHIFT 15
`define MSC_FILT_Y_SHIFT 16
`define MSC_LEAD_X_SHIFT 17
`define MSC_LEAD_Y_SHIFT 16

`endif

// ---- hdl/msc_pz_stage.v ----
// One-pole one-zero section used for the loop filter and the lead compensator
module msc_pz_stage #(
  parameter DW = 18,
  parameter CW = 12,
  parameter X_SHIFT = 15,
  parameter Y_SHIFT = 16
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_clear,
  input wire i_sample,
  input wire i_bypass,
  input wire [CW-1:0] i_zero_coeff,
  input wire [CW-1:0] i_pole_coeff,
  input wire signed [DW-1:0] i_x,
  output wire signed [DW-1:0] o_y
);
  localparam PW = DW + CW + 4;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  reg signed [DW-1:0] y;
  reg signed [DW-1:0] x_prev;
  wire signed [PW-1:0] xe = {{(PW-DW){i_x[DW-1]}}, i_x};
  wire signed [PW-1:0] pe = {{(PW-DW){x_prev[DW-1]}}, x_prev};
  wire signed [PW-1:0] ye = {{(PW-DW){y[DW-1]}}, y};
  wire signed [PW-1:0] kz = {{(PW-CW){1'b0}}, i_zero_coeff};
  wire signed [PW-1:0] kp = {{(PW-CW){1'b0}}, i_pole_coeff};
  wire signed [PW-1:0] xk = xe * kz;
  wire signed [PW-1:0] yk = ye * kp;
  // Gain term, pole feedback and a first difference that places the zero
  wire signed [PW-1:0] sum = ye + (xk >>> X_SHIFT) - (yk >>> Y_SHIFT) + (xe - pe);

  // Clamp to the data range so a large step cannot flip the sign
  function [DW-1:0] sat_dw;
    input [PW-1:0] v;
    begin
      if (v[PW-1] == 1'b0 && v[PW-2:DW-1] != {(PW-DW){1'b0}}) begin
        sat_dw = {1'b0, {(DW-1){1'b1}}};
      end else if (v[PW-1] == 1'b1 && v[PW-2:DW-1] != {(PW-DW){1'b1}}) begin
        sat_dw = {1'b1, {(DW-1){1'b0}}};
      end else begin
        sat_dw = v[DW-1:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State update at the sample rate
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      y <= {DW{1'b0}};
      x_prev <= {DW{1'b0}};
    end else if (i_clear) begin
      y <= {DW{1'b0}};
      x_prev <= {DW{1'b0}};
    end else if (i_sample) begin
      y <= sat_dw(sum);
      x_prev <= i_x;
    end
  end

  // Bypass passes the input through untouched
  assign o_y = i_bypass ? i_x : y;
endmodule

// ---- hdl/msc_loop.v ----
// Speed command path: input modes, differentiator, integrator, filter and lead
`include "msc_map.vh"
module msc_loop #(
  parameter IW = 16,
  parameter DW = 18,
  parameter CW = 12,
  parameter DIVW = 8,
  parameter PERW = 16,
  parameter OUT_SHIFT = 4
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_enable,
  input wire i_brake,
  input wire [1:0] i_speed_source_select,
  input wire [1:0] i_feedback_source_select,
  input wire i_speed_reference_in,
  input wire i_feedback_amp_in,
  input wire i_rotation_pulse_input,
  input wire [2:0] i_hall,
  input wire [11:0] i_integrator_step,
  input wire [DIVW-1:0] i_integrator_clock_divider,
  input wire [CW-1:0] i_filter_pole_coeff,
  input wire [CW-1:0] i_filter_zero_coeff,
  input wire i_filter_bypass,
  input wire [CW-1:0] i_lead_pole_coeff,
  input wire [CW-1:0] i_lead_zero_coeff,
  input wire i_lead_bypass,
  input wire [11:0] i_fixed_modulation_scale,
  input wire [11:0] i_speed_command,
  output reg [11:0] o_duty_cmd,
  output reg o_speed_feedback_out,
  output reg o_up,
  output reg o_down,
  output reg [IW-1:0] o_integrator
);
  localparam NPIN = 6;
  localparam [IW-1:0] INT_MAX = {IW{1'b1}};
  localparam [PERW-1:0] PER_MAX = {PERW{1'b1}};
  localparam integer SAMPLE_DIV = `MSC_SAMPLE_DIV;
  localparam integer BASE_DIV = `MSC_BASE_DIV;
  localparam [9:0] SAMPLE_LAST = SAMPLE_DIV[9:0] - 10'h001;
  localparam [1:0] BASE_LAST = BASE_DIV[1:0] - 2'h1;

  // Clamp a wide unsigned value to the 12-bit duty range
  function [11:0] sat12;
    input [31:0] v;
    begin
      if (v > {20'h00000, `MSC_DUTY_MAX}) begin
        sat12 = `MSC_DUTY_MAX;
      end else begin
        sat12 = v[11:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and deglitch
  // ----------------------------------------------------------------
  wire [NPIN-1:0] pin_raw = {i_hall, i_rotation_pulse_input, i_feedback_amp_in,
                             i_speed_reference_in};
  reg [NPIN-1:0] pin_s1;
  reg [NPIN-1:0] pin_s2;
  reg [NPIN-1:0] pin_s3;
  reg [NPIN-1:0] pin_clean;
  reg [NPIN-1:0] pin_prev;

  // A pin only changes once two later stages agree, which drops one-cycle glitches
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          pin_s1[g] <= 1'b0;
          pin_s2[g] <= 1'b0;
          pin_s3[g] <= 1'b0;
          pin_clean[g] <= 1'b0;
          pin_prev[g] <= 1'b0;
        end else begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          if (pin_s2[g] == pin_s3[g]) begin
            pin_clean[g] <= pin_s3[g];
          end
          pin_prev[g] <= pin_clean[g];
        end
      end
    end
  endgenerate

  wire ref_level = pin_clean[0];
  wire ref_rise = pin_clean[0] & ~pin_prev[0];

  // Feedback source choice; a single Hall channel keeps sensor mismatch out of the loop
  reg fb_level;
  always @* begin
    case (i_feedback_source_select)
      `MSC_FB_AMP: fb_level = pin_clean[1];
      `MSC_FB_ROTATION: fb_level = pin_clean[2];
      `MSC_FB_HALL: fb_level = pin_clean[3];
      default: fb_level = pin_clean[1];
    endcase
  end

  reg fb_prev;
  wire fb_rise = fb_level & ~fb_prev;

  // ----------------------------------------------------------------
  // Enables: base clock, integrator clock, sample clock
  // ----------------------------------------------------------------
  reg [1:0] base_cnt;
  reg [DIVW-1:0] int_cnt;
  reg [9:0] sample_cnt;
  reg enable_prev;
  wire base_en = (base_cnt == BASE_LAST);
  wire [DIVW-1:0] int_last = (i_integrator_clock_divider == {DIVW{1'b0}}) ?
                             {DIVW{1'b0}} : i_integrator_clock_divider - 1'b1;
  wire int_en = base_en && (int_cnt == int_last);
  wire sample_en = (sample_cnt == SAMPLE_LAST);
  wire enable_rise = i_enable & ~enable_prev;
  wire loop_clear = ~i_enable | i_brake | enable_rise;
  wire filt_clear = ~i_enable | enable_rise;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      base_cnt <= 2'h0;
      int_cnt <= {DIVW{1'b0}};
      sample_cnt <= 10'h000;
      enable_prev <= 1'b0;
      fb_prev <= 1'b0;
    end else begin
      base_cnt <= base_en ? 2'h0 : base_cnt + 2'h1;
      if (base_en) begin
        int_cnt <= (int_cnt >= int_last) ? {DIVW{1'b0}} : int_cnt + 1'b1;
      end
      sample_cnt <= sample_en ? 10'h000 : sample_cnt + 10'h001;
      enable_prev <= i_enable;
      fb_prev <= fb_level;
    end
  end

  // ----------------------------------------------------------------
  // Speed differentiator
  // ----------------------------------------------------------------
  // Each side arms on its own rising edge; once both are armed they cancel, so the
  // width of UP or DOWN is the lead of one edge over the other
  reg up_arm;
  reg down_arm;
  wire next_up = up_arm | ref_rise;
  wire next_down = down_arm | fb_rise;
  wire freq_mode = (i_speed_source_select == `MSC_MODE_FREQ);

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      up_arm <= 1'b0;
      down_arm <= 1'b0;
    end else if (loop_clear || !freq_mode || (next_up && next_down)) begin
      up_arm <= 1'b0;
      down_arm <= 1'b0;
    end else begin
      up_arm <= next_up;
      down_arm <= next_down;
    end
  end

  // With the reference stopped, feedback edges keep DOWN armed; it is dropped at zero
  wire up_act = up_arm;
  wire down_act = down_arm && (o_integrator != {IW{1'b0}});

  // ----------------------------------------------------------------
  // Integrator
  // ----------------------------------------------------------------
  wire [IW-1:0] step = {{(IW-12){1'b0}}, i_integrator_step};
  reg [IW-1:0] next_integ;
  always @* begin
    next_integ = o_integrator;
    if (int_en && up_act && !down_act) begin
      if (o_integrator > INT_MAX - step) begin
        next_integ = INT_MAX;
      end else begin
        next_integ = o_integrator + step;
      end
    end else if (int_en && down_act && !up_act) begin
      if (o_integrator < step) begin
        next_integ = {IW{1'b0}};
      end else begin
        next_integ = o_integrator - step;
      end
    end
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_integrator <= {IW{1'b0}};
      o_up <= 1'b0;
      o_down <= 1'b0;
    end else if (loop_clear) begin
      o_integrator <= {IW{1'b0}};
      o_up <= 1'b0;
      o_down <= 1'b0;
    end else begin
      o_integrator <= next_integ;
      o_up <= up_act;
      o_down <= down_act;
    end
  end

  // ----------------------------------------------------------------
  // Loop filter and lead compensator
  // ----------------------------------------------------------------
  wire signed [DW-1:0] filt_in = {{(DW-IW){1'b0}}, o_integrator};
  wire signed [DW-1:0] filt_out;
  wire signed [DW-1:0] lead_out;

  msc_pz_stage #(
    .DW(DW),
    .CW(CW),
    .X_SHIFT(`MSC_FILT_X_SHIFT),
    .Y_SHIFT(`MSC_FILT_Y_SHIFT)
  ) u_filter (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clear(filt_clear),
    .i_sample(sample_en),
    .i_bypass(i_filter_bypass),
    .i_zero_coeff(i_filter_zero_coeff),
    .i_pole_coeff(i_filter_pole_coeff),
    .i_x(filt_in),
    .o_y(filt_out)
  );

  msc_pz_stage #(
    .DW(DW),
    .CW(CW),
    .X_SHIFT(`MSC_LEAD_X_SHIFT),
    .Y_SHIFT(`MSC_LEAD_Y_SHIFT)
  ) u_lead (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clear(filt_clear),
    .i_sample(sample_en),
    .i_bypass(i_lead_bypass),
    .i_zero_coeff(i_lead_zero_coeff),
    .i_pole_coeff(i_lead_pole_coeff),
    .i_x(filt_out),
    .o_y(lead_out)
  );

  // Negative compensator output means no drive rather than a reversed command
  wire [DW-1:0] lead_shift = lead_out >>> OUT_SHIFT;
  wire [11:0] loop_duty = lead_out[DW-1] ? 12'h000 :
                          sat12({{(32-DW){1'b0}}, lead_shift});

  // ----------------------------------------------------------------
  // Open-loop duty measurement of the reference clock
  // ----------------------------------------------------------------
  reg [PERW-1:0] period_cnt;
  reg [PERW-1:0] high_cnt;
  reg [11:0] meas_duty;
  wire [PERW+11:0] high_scaled = {high_cnt, 12'h000};
  wire [PERW+11:0] period_ext = {12'h000, period_cnt};
  // A single wide divide per reference period; area traded for simplicity
  wire [PERW+11:0] ratio = high_scaled / period_ext;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      period_cnt <= {PERW{1'b0}};
      high_cnt <= {PERW{1'b0}};
      meas_duty <= 12'h000;
    end else if (ref_rise) begin
      if (period_cnt != {PERW{1'b0}}) begin
        meas_duty <= sat12({{(20-PERW){1'b0}}, ratio});
      end
      period_cnt <= {PERW{1'b0}};
      high_cnt <= {PERW{1'b0}};
    end else if (base_en) begin
      if (period_cnt == PER_MAX) begin
        meas_duty <= ref_level ? `MSC_DUTY_MAX : 12'h000; // Stuck reference
      end else begin
        period_cnt <= period_cnt + 1'b1;
        high_cnt <= high_cnt + {{(PERW-1){1'b0}}, ref_level};
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode selection and modulation scaling
  // ----------------------------------------------------------------
  reg [11:0] open_duty;
  always @* begin
    case (i_speed_source_select)
      `MSC_MODE_CLK_DUTY: open_duty = meas_duty;
      `MSC_MODE_REG_DUTY: open_duty = i_speed_command;
      default: open_duty = 12'h000;
    endcase
  end

  wire [23:0] scaled = {12'h000, open_duty} * {12'h000, i_fixed_modulation_scale};
  wire [23:0] scaled_shift = scaled >> `MSC_MOD_SHIFT;

  // Output register; duty is zero whenever the motor is disabled or braking
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_duty_cmd <= 12'h000;
      o_speed_feedback_out <= 1'b0;
    end else begin
      o_speed_feedback_out <= fb_level;
      if (!i_enable || i_brake) begin
        o_duty_cmd <= 12'h000;
      end else if (freq_mode) begin
        o_duty_cmd <= loop_duty;
      end else begin
        o_duty_cmd <= sat12({8'h00, scaled_shift});
      end
    end
  end
endmodule

// ---- dv/msc_far_side.sv ----
// Model of the reference clock source and the three speed feedback sensors
module msc_far_side (
  input wire logic i_clk,
  input wire logic [15:0] i_ref_high,
  input wire logic [15:0] i_ref_low,
  input wire logic [15:0] i_fb_half,
  output logic o_ref,
  output logic o_amp,
  output logic o_rot,
  output logic [2:0] o_hall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rcnt = 16'h0;
  logic [15:0] fcnt = 16'h0;
  logic ref_q = 1'b0;
  logic fb = 1'b0;
  // Reference wave; a zero time parks it low, as a stopped source would
  always @(posedge i_clk) begin
    if (i_ref_high == 16'h0 || i_ref_low == 16'h0) begin
      rcnt <= 16'h0;
      ref_q <= 1'b0;
    end else if (rcnt + 16'h1 >= (ref_q ? i_ref_high : i_ref_low)) begin
      rcnt <= 16'h0;
      ref_q <= ~ref_q;
    end else begin
      rcnt <= rcnt + 16'h1;
    end
  end
  // Shaft feedback; a stopped shaft holds its last level
  always @(posedge i_clk) begin
    if (i_fb_half != 16'h0 && fcnt + 16'h1 >= i_fb_half) begin
      fcnt <= 16'h0;
      fb <= ~fb;
    end else if (i_fb_half != 16'h0) begin
      fcnt <= fcnt + 16'h1;
    end
  end
  // All three sensor kinds see one shaft, pulse pickup inverted
  assign o_ref = ref_q;
  assign o_amp = fb;
  assign o_rot = ~fb;
  assign o_hall = {fb, ~fb, fb};
endmodule

// ---- dv/msc_loop_chk.sv ----
// Port-level assertions for the speed command loop
`include "msc_map.vh"
module msc_loop_chk #(parameter IW = 16) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_brake,
  input wire logic [1:0] i_speed_source_select,
  input wire logic [1:0] i_feedback_source_select,
  input wire logic i_speed_reference_in,
  input wire logic i_feedback_amp_in,
  input wire logic i_rotation_pulse_input,
  input wire logic [2:0] i_hall,
  input wire logic [11:0] i_fixed_modulation_scale,
  input wire logic [11:0] i_speed_command,
  input wire logic [11:0] o_duty_cmd,
  input wire logic o_speed_feedback_out,
  input wire logic o_up,
  input wire logic o_down,
  input wire logic [IW-1:0] o_integrator
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [3:0] rst_cnt;
  wire en_ok = i_enable && !i_brake && rst_cnt == 4'h8;
  wire fb_pin = (i_feedback_source_select == `MSC_FB_ROTATION) ? i_rotation_pulse_input :
    (i_feedback_source_select == `MSC_FB_HALL) ? i_hall[0] : i_feedback_amp_in;
  // Settle count, so synchronisers flush old pin values after reset
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rst_cnt <= 4'h0;
    end else if (rst_cnt != 4'h8) begin
      rst_cnt <= rst_cnt + 4'h1;
    end
  end
  function automatic logic [11:0] scaled(input logic [11:0] c, input logic [11:0] s);
    logic [23:0] p;
    p = ({12'h0, c} * {12'h0, s}) >> 11;
    return (p > 24'hFFF) ? 12'hFFF : p[11:0];
  endfunction
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_off; !i_enable || i_brake; endsequence
  sequence s_run2; en_ok ##1 en_ok; endsequence
  sequence s_fb_settled;
    ($stable(fb_pin) && $stable(i_feedback_source_select) && rst_cnt == 4'h8)[*8];
  endsequence
  sequence s_ref_quiet; ($stable(i_speed_reference_in) && rst_cnt == 4'h8)[*8]; endsequence
  property p_off_int; s_off |=> o_integrator == '0; endproperty
  property p_off_ud; s_off |=> !o_up && !o_down; endproperty
  property p_off_duty; s_off |=> o_duty_cmd == 12'h0; endproperty
  // Up and down are registered alongside the integrator, so both are judged at the same edge
  property p_hold; s_run2 ##0 (!o_up && !o_down) |-> $stable(o_integrator); endproperty
  property p_up_rise; s_run2 ##0 (o_up && !o_down) |-> o_integrator >= $past(o_integrator);
  endproperty
  property p_no_wrap;
    s_run2 |-> ((o_integrator >= $past(o_integrator)) ? (o_integrator - $past(o_integrator))
      : ($past(o_integrator) - o_integrator)) <= 16'hFFF;
  endproperty
  property p_reg; en_ok && i_speed_source_select == `MSC_MODE_REG_DUTY
    |=> o_duty_cmd == scaled($past(i_speed_command), $past(i_fixed_modulation_scale));
  endproperty
  property p_idle_mode; en_ok && i_speed_source_select == 2'h3 |=> o_duty_cmd == 12'h0;
  endproperty
  property p_fb; s_fb_settled |-> o_speed_feedback_out == fb_pin; endproperty
  property p_no_up; s_ref_quiet ##0 !o_up |=> !o_up; endproperty
  a_off_int: assert property (p_off_int) else $error("integrator not cleared");
  a_off_ud: assert property (p_off_ud) else $error("up or down while off");
  a_off_duty: assert property (p_off_duty) else $error("duty while off");
  a_hold: assert property (p_hold) else $error("integrator moved while idle");
  a_up_rise: assert property (p_up_rise) else $error("integrator fell on up");
  a_no_wrap: assert property (p_no_wrap) else $error("integrator jumped");
  a_reg: assert property (p_reg) else $error("register duty wrong");
  a_idle_mode: assert property (p_idle_mode) else $error("unused mode drives duty");
  a_fb: assert property (p_fb) else $error("feedback source mismatch");
  a_no_up: assert property (p_no_up) else $error("up with quiet reference");
endmodule
bind msc_loop msc_loop_chk #(.IW(IW)) u_msc_loop_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_enable(i_enable),
  .i_brake(i_brake),
  .i_speed_source_select(i_speed_source_select),
  .i_feedback_source_select(i_feedback_source_select),
  .i_speed_reference_in(i_speed_reference_in),
  .i_feedback_amp_in(i_feedback_amp_in),
  .i_rotation_pulse_input(i_rotation_pulse_input),
  .i_hall(i_hall),
  .i_fixed_modulation_scale(i_fixed_modulation_scale),
  .i_speed_command(i_speed_command),
  .o_duty_cmd(o_duty_cmd),
  .o_speed_feedback_out(o_speed_feedback_out),
  .o_up(o_up),
  .o_down(o_down),
  .o_integrator(o_integrator)
);

// ---- dv/msc_loop_test.sv ----
// Self-checking bench for the speed command loop
`include "msc_map.vh"
module msc_loop_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus, observation and tallies
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic en = 1'b0, brk = 1'b0, fbyp = 1'b1, lbyp = 1'b1;
  logic [1:0] mode = 2'h0, fbsel = 2'h0;
  logic [11:0] step = 12'h010, scale = 12'h800, cmd = 12'h000;
  logic [11:0] fkp = 12'h100, fkz = 12'h100, lkp = 12'h100, lkz = 12'h100;
  logic [7:0] div = 8'h01;
  logic [15:0] ref_hi = 16'h0, ref_lo = 16'h0, fb_half = 16'h0;
  logic ref_in, amp, rot, fbo, up, down;
  logic [2:0] hall;
  logic [11:0] duty;
  logic [15:0] integ;
  int n_errors = 0, n_tests = 0, cyc = 0;
  msc_loop u_msc_loop (.i_clk(i_clk), .i_reset(i_reset), .i_enable(en), .i_brake(brk),
    .i_speed_source_select(mode), .i_feedback_source_select(fbsel),
    .i_speed_reference_in(ref_in), .i_feedback_amp_in(amp), .i_rotation_pulse_input(rot),
    .i_hall(hall), .i_integrator_step(step), .i_integrator_clock_divider(div),
    .i_filter_pole_coeff(fkp), .i_filter_zero_coeff(fkz), .i_filter_bypass(fbyp),
    .i_lead_pole_coeff(lkp), .i_lead_zero_coeff(lkz), .i_lead_bypass(lbyp),
    .i_fixed_modulation_scale(scale), .i_speed_command(cmd), .o_duty_cmd(duty),
    .o_speed_feedback_out(fbo), .o_up(up), .o_down(down), .o_integrator(integ));
  msc_far_side u_msc_far_side (.i_clk(i_clk), .i_ref_high(ref_hi), .i_ref_low(ref_lo),
    .i_fb_half(fb_half), .o_ref(ref_in), .o_amp(amp), .o_rot(rot), .o_hall(hall));
  // 100 MHz clock
  initial forever #5 i_clk = ~i_clk;
  // Hang guard, sized well above the 26k cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      $display("BAD t=%0t timeout", $time);
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    n_tests++;
    if (act !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h want %h", $time, act, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Applies mode, enable and far-side wave settings on one edge
  task automatic setup(input logic [1:0] m, input logic e, input logic [15:0] rh,
                       input logic [15:0] rl, input logic [15:0] fh);
    @(posedge i_clk);
    mode <= m;
    en <= e;
    ref_hi <= rh;
    ref_lo <= rl;
    fb_half <= fh;
  endtask
  function automatic logic [11:0] want_duty(input logic [11:0] c, input logic [11:0] s);
    logic [23:0] p;
    p = ({12'h0, c} * {12'h0, s}) >> 11;
    return (p > 24'hFFF) ? 12'hFFF : p[11:0];
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    static logic [11:0] tc [4] = '{12'h800, 12'hFFF, 12'h400, 12'h123};
    static logic [11:0] ts [4] = '{12'h800, 12'hFFF, 12'hFFF, 12'h800};
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_cyc(1);
    chk(integ, 16'h0);
    $display("test reset done");
    // Register duty, including the saturating full-scale pair
    setup(`MSC_MODE_REG_DUTY, 1'b1, 16'h0, 16'h0, 16'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      cmd <= tc[i];
      scale <= ts[i];
      wait_cyc(2);
      chk({4'h0, duty}, {4'h0, want_duty(tc[i], ts[i])});
    end
    setup(2'h3, 1'b1, 16'h0, 16'h0, 16'h0);
    wait_cyc(2);
    chk({4'h0, duty}, 16'h0);
    $display("test register duty done");
    // Clock duty of one quarter, at unity and at full-scale modulation
    setup(`MSC_MODE_CLK_DUTY, 1'b1, 16'h28, 16'h78, 16'h0);
    scale <= 12'h800;
    wait_cyc(1200);
    chk(16'(duty > 12'h3C0 && duty < 12'h440), 16'h1);
    @(posedge i_clk);
    scale <= 12'hFFF;
    wait_cyc(1200);
    chk(16'(duty > 12'h7C0 && duty < 12'h840), 16'h1);
    $display("test clock duty done");
    // Closed loop with no feedback: up holds and the integrator pins at full scale
    setup(`MSC_MODE_FREQ, 1'b0, 16'h32, 16'h32, 16'h0);
    setup(`MSC_MODE_FREQ, 1'b1, 16'h32, 16'h32, 16'h0);
    wait_cyc(300);
    chk(up, 16'h1);
    chk(16'(integ != 16'h0), 16'h1);
    wait_cyc(10000);
    chk(integ, 16'hFFFF);
    chk({4'h0, duty}, 16'h0FFF);
    $display("test closed loop done");
    // Reference stops while feedback runs through every source choice
    setup(`MSC_MODE_FREQ, 1'b1, 16'h0, 16'h0, 16'h14);
    // Two feedback rises arm DOWN well inside this wait; the integrator is still high
    wait_cyc(200);
    chk(down, 16'h1);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      fbsel <= s[1:0];
      wait_cyc(2600);
    end
    chk(integ, 16'h0);
    chk({4'h0, duty}, 16'h0);
    $display("test reference stop done");
    // Brake in mid-climb, then filters live so the off state must clear them
    setup(`MSC_MODE_FREQ, 1'b1, 16'h32, 16'h32, 16'h0);
    wait_cyc(400);
    @(posedge i_clk);
    brk <= 1'b1;
    wait_cyc(2);
    chk(integ, 16'h0);
    @(posedge i_clk);
    brk <= 1'b0;
    fbyp <= 1'b0;
    lbyp <= 1'b0;
    fkz <= 12'h080;
    lkz <= 12'h200;
    wait_cyc(1100);
    setup(`MSC_MODE_FREQ, 1'b0, 16'h0, 16'h0, 16'h0);
    wait_cyc(600);
    setup(`MSC_MODE_FREQ, 1'b1, 16'h0, 16'h0, 16'h0);
    wait_cyc(1200);
    chk(up, 16'h0);
    chk(integ, 16'h0);
    chk({4'h0, duty}, 16'h0);
    $display("test restart done");
    tally_and_finish();
  end
endmodule
